// ==== asc_seq_ctrl.sv ====
// Purpose: Conversion sequencer and start-event logic
// Assumes: Base clock is clk; register port read data valid one cycle after read strobe
// Notes:   conv_start pulses once per conversion with conv_sel beside it
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module asc_seq_ctrl
	import asc_pkg::*;
#(
	parameter logic [31:0] BASE_CLK_HZ = ASC_BASE_CLK_HZ
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        ext_trig_in,
	input  wire logic        ext_start_in,
	output logic             conv_start,
	output asc_conv_s        conv_sel,
	output logic             acq_running
);
	logic [31:0] control_q;
	logic [31:0] rate_div_q;
	logic [31:0] scan_div_q;
	logic [31:0] ch_gain_q;
	logic [3:0]  ext_ctrl_q;
	asc_acq_e    acq_q;
	logic [2:0]  chan_q;
	logic        scan_busy_q;
	logic [2:0]  trig_sync_q;
	logic [2:0]  start_sync_q;

	asc_seq_e    seq_mode;
	logic [2:0]  last_ch;
	logic [3:0]  common_gain;
	logic        scan_mode;
	logic        ctl_wr;
	logic        wr_start;
	logic        wr_stop;
	logic        wr_start_q;
	logic        trig_edge;
	logic        start_edge;
	logic        periodic_tick;
	logic        scan_tick;
	logic        start_event;
	logic        do_conv;
	logic        scan_last;

	function automatic logic sel_edge(input logic prev, input logic cur, input logic fall);
		sel_edge = fall ? (prev & ~cur) : (~prev & cur);
	endfunction

	assign seq_mode    = asc_seq_e'(control_q[ASC_CTL_SEQ_LSB +: 2]);
	assign last_ch     = control_q[ASC_CTL_LAST_CH_LSB +: 3];
	assign common_gain = {1'b0, control_q[ASC_CTL_GAIN_LSB +: 3]};
	assign scan_mode   = control_q[ASC_CTL_SCAN_BIT] && seq_mode != ASC_SEQ_NONE && last_ch != 3'h0;

	assign ctl_wr   = reg_wr && reg_addr == ASC_OFS_CONTROL;
	assign wr_start = ctl_wr && reg_wdata[ASC_CTL_START_BIT];
	assign wr_stop  = ctl_wr && !reg_wdata[ASC_CTL_START_BIT];

	// Register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			control_q  <= ASC_RST_CONTROL;
			rate_div_q <= ASC_RST_DIV;
			scan_div_q <= ASC_RST_DIV;
			ch_gain_q  <= ASC_RST_GAIN;
			ext_ctrl_q <= 4'h0;
		end else if (reg_wr) begin
			case (reg_addr)
				ASC_OFS_CONTROL:  control_q  <= reg_wdata;
				ASC_OFS_RATE_DIV: rate_div_q <= reg_wdata;
				ASC_OFS_SCAN_DIV: scan_div_q <= reg_wdata;
				ASC_OFS_CH_GAIN:  ch_gain_q  <= reg_wdata;
				ASC_OFS_EXT_CTRL: ext_ctrl_q <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// Start acts one cycle after the write so the new control fields are already in place
	always_ff @(posedge clk) begin
		if (!resetn)
			wr_start_q <= 1'b0;
		else
			wr_start_q <= wr_start;
	end

	// Register reads, data in the following cycle only
	always_ff @(posedge clk) begin
		if (!resetn || !reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				ASC_OFS_BASE_CLK: reg_rdata <= BASE_CLK_HZ;
				ASC_OFS_RATE_DIV: reg_rdata <= rate_div_q;
				ASC_OFS_SCAN_DIV: reg_rdata <= scan_div_q;
				ASC_OFS_CH_GAIN:  reg_rdata <= ch_gain_q;
				ASC_OFS_CONTROL:  reg_rdata <= control_q;
				ASC_OFS_EXT_CTRL: reg_rdata <= {28'h0, ext_ctrl_q};
				ASC_OFS_STATUS:   reg_rdata <= {24'h0, scan_busy_q, chan_q, 2'b00, acq_q};
				default:          reg_rdata <= ASC_RD_UNMAPPED;
			endcase
		end
	end

	// Stage 0 feeds only stage 1; edges compare stages 1 and 2
	always_ff @(posedge clk) begin
		if (!resetn) begin
			trig_sync_q  <= 3'b000;
			start_sync_q <= 3'b000;
		end else begin
			trig_sync_q  <= {trig_sync_q[1:0], ext_trig_in};
			start_sync_q <= {start_sync_q[1:0], ext_start_in};
		end
	end

	assign trig_edge  = ext_ctrl_q[ASC_EXT_TRIG_EN_BIT] &&
		sel_edge(trig_sync_q[2], trig_sync_q[1], ext_ctrl_q[ASC_EXT_TRIG_FALL_BIT]);
	assign start_edge = ext_ctrl_q[ASC_EXT_START_EN_BIT] &&
		sel_edge(start_sync_q[2], start_sync_q[1], ext_ctrl_q[ASC_EXT_START_FALL_BIT]);

	// Acquisition state: idle, armed awaiting trigger, running periodic
	always_ff @(posedge clk) begin
		if (!resetn) begin
			acq_q <= ASC_ST_IDLE;
		end else if (wr_stop) begin
			acq_q <= ASC_ST_IDLE;
		end else if (wr_start) begin
			if (rate_div_q == 32'h0)
				acq_q <= ASC_ST_IDLE;
			else if (ext_ctrl_q[ASC_EXT_TRIG_EN_BIT])
				acq_q <= ASC_ST_ARMED;
			else
				acq_q <= ASC_ST_RUN;
		end else begin
			case (acq_q)
				ASC_ST_ARMED: if (trig_edge) acq_q <= ASC_ST_RUN;
				ASC_ST_RUN:   acq_q <= ASC_ST_RUN;
				ASC_ST_IDLE:  acq_q <= ASC_ST_IDLE;
				default:      acq_q <= ASC_ST_IDLE;
			endcase
		end
	end

	// Periodic timer restarts on start, stop and trigger
	asc_divider #(.WIDTH(32)) u_rate_div (
		.clk     (clk),
		.resetn  (resetn),
		.run     (acq_q == ASC_ST_RUN),
		.restart (ctl_wr || (acq_q == ASC_ST_ARMED && trig_edge)),
		.div     (rate_div_q),
		.tick    (periodic_tick)
	);

	// Intra-scan pacing counts from the scan's first conversion, so spacing equals the divisor
	asc_divider #(.WIDTH(32)) u_scan_div (
		.clk     (clk),
		.resetn  (resetn),
		.run     (scan_mode && (scan_busy_q || start_event)),
		.restart (!scan_mode),
		.div     (scan_div_q),
		.tick    (scan_tick)
	);

	// Immediate start unless arming; triggered runs start on the edge itself
	assign start_event = (wr_start_q && !(rate_div_q != 32'h0 && ext_ctrl_q[ASC_EXT_TRIG_EN_BIT]))
		|| (acq_q == ASC_ST_ARMED && trig_edge && !ctl_wr)
		|| (acq_q == ASC_ST_RUN && periodic_tick && !ctl_wr)
		|| start_edge;

	// Starts arriving mid-scan are dropped; zero scan divisor converts back to back
	assign scan_last = chan_q == last_ch;
	assign do_conv   = scan_mode ? ((start_event && !scan_busy_q) || (scan_busy_q && (scan_tick || scan_div_q == 32'h0)))
	                             : start_event;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			scan_busy_q <= 1'b0;
		end else if (!scan_mode) begin
			scan_busy_q <= 1'b0;
		end else if (do_conv && !scan_busy_q) begin
			scan_busy_q <= 1'b1;
		end else if (do_conv && scan_last) begin
			scan_busy_q <= 1'b0;
		end
	end

	// Channel pointer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			chan_q <= 3'h0;
		end else if (seq_mode == ASC_SEQ_NONE) begin
			chan_q <= 3'h0;
		end else if (ctl_wr && seq_mode != ASC_SEQ_MODBS &&
		             reg_wdata[ASC_CTL_SEQ_LSB +: 2] != 2'(ASC_SEQ_MODBS)) begin
			chan_q <= 3'h0;
		end else if (scan_mode && start_event && !scan_busy_q) begin
			chan_q <= (last_ch == 3'h0) ? 3'h0 : 3'h1;
		end else if (do_conv) begin
			chan_q <= (chan_q >= last_ch) ? 3'h0 : chan_q + 3'h1;
		end
	end

	// Conversion output
	always_ff @(posedge clk) begin
		if (!resetn) begin
			conv_start <= 1'b0;
			conv_sel   <= '0;
		end else begin
			conv_start <= do_conv;
			if (do_conv) begin
				case (seq_mode)
					ASC_SEQ_NONE: begin
						conv_sel.channel <= last_ch;
						conv_sel.gain    <= common_gain;
					end
					ASC_SEQ_ADV: begin
						conv_sel.channel <= (scan_mode && !scan_busy_q) ? 3'h0 : chan_q;
						conv_sel.gain    <= ch_gain_q[4*((scan_mode && !scan_busy_q) ? 3'h0 : chan_q) +: 4];
					end
					ASC_SEQ_MODBS, ASC_SEQ_BASIC: begin
						conv_sel.channel <= (scan_mode && !scan_busy_q) ? 3'h0 : chan_q;
						conv_sel.gain    <= common_gain;
					end
					default: begin
						conv_sel.channel <= 3'h0;
						conv_sel.gain    <= common_gain;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn)
			acq_running <= 1'b0;
		else
			acq_running <= acq_q != ASC_ST_IDLE || scan_busy_q;
	end
endmodule
`default_nettype wire

// ==== asc_pkg.sv ====
// Purpose: Shared constants and types for the acquisition sequencer and start control
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes:   Control register bit positions collected here; trigger/start enables sit in a local register
package asc_pkg;

	localparam logic [7:0] ASC_OFS_BASE_CLK  = 8'h0C;
	localparam logic [7:0] ASC_OFS_RATE_DIV  = 8'h10;
	localparam logic [7:0] ASC_OFS_SCAN_DIV  = 8'h14;
	localparam logic [7:0] ASC_OFS_CH_GAIN   = 8'h18;
	localparam logic [7:0] ASC_OFS_CONTROL   = 8'h38;
	localparam logic [7:0] ASC_OFS_EXT_CTRL  = 8'h48;
	localparam logic [7:0] ASC_OFS_STATUS    = 8'h3C;

	// Control register field positions
	localparam int ASC_CTL_LAST_CH_LSB = 0;
	localparam int ASC_CTL_GAIN_LSB    = 4;
	localparam int ASC_CTL_SEQ_LSB     = 8;
	localparam int ASC_CTL_START_BIT   = 16;
	localparam int ASC_CTL_SCAN_BIT    = 18;

	// External input control field positions
	localparam int ASC_EXT_TRIG_EN_BIT   = 0;
	localparam int ASC_EXT_TRIG_FALL_BIT = 1;
	localparam int ASC_EXT_START_EN_BIT  = 2;
	localparam int ASC_EXT_START_FALL_BIT = 3;

	localparam logic [31:0] ASC_RST_CONTROL = 32'h0000_0000;
	localparam logic [31:0] ASC_RST_DIV     = 32'h0000_0000;
	localparam logic [31:0] ASC_RST_GAIN    = 32'h0000_0000;
	localparam logic [31:0] ASC_BASE_CLK_HZ = 32'h0BEB_C200;
	localparam logic [31:0] ASC_RD_UNMAPPED = 32'h0000_0000;

	localparam int ASC_NUM_CH = 8;

	typedef enum logic [1:0] {
		ASC_SEQ_NONE  = 2'b00,
		ASC_SEQ_MODBS = 2'b01,
		ASC_SEQ_ADV   = 2'b10,
		ASC_SEQ_BASIC = 2'b11
	} asc_seq_e;

	typedef enum logic [1:0] {
		ASC_ST_IDLE  = 2'b00,
		ASC_ST_ARMED = 2'b01,
		ASC_ST_RUN   = 2'b10
	} asc_acq_e;

	typedef struct packed {
		logic [2:0] channel;
		logic [3:0] gain;
	} asc_conv_s;

endpackage

// ==== asc_divider.sv ====
// Purpose: Reloading cycle divider producing a one-cycle tick
// Assumes: div of zero means stopped
// Notes:   Restart clears the count so the first tick lands a full period later
`timescale 1ns/1ps
`default_nettype none
module asc_divider
	import asc_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             run,
	input  wire logic             restart,
	input  wire logic [WIDTH-1:0] div,
	output logic                  tick
);
	logic [WIDTH-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (!resetn || restart || !run || div == '0) begin
			cnt_q <= '0;
			tick  <= 1'b0;
		end else if (cnt_q >= div - 1'b1) begin
			cnt_q <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== asc_chk_sva.sv ====
// Purpose: Port assertions for the sequencer
// Assumes: Shadows track the registers these checks need
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module asc_chk
	import asc_pkg::*;
#(
	parameter logic [31:0] BASE_CLK_HZ = ASC_BASE_CLK_HZ
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        ext_trig_in,
	input wire logic        ext_start_in,
	input wire logic        conv_start,
	input wire asc_conv_s   conv_sel,
	input wire logic        acq_running
);
	logic [31:0] ctl_q;
	logic [31:0] rate_q;
	logic [3:0]  ext_q;
	wire logic   start_wr = reg_wr && reg_addr == 8'h38 && reg_wdata[16];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctl_q  <= 32'h0;
			rate_q <= 32'h0;
			ext_q  <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == 8'h38)
				ctl_q <= reg_wdata;
			if (reg_addr == 8'h10)
				rate_q <= reg_wdata;
			if (reg_addr == 8'h48)
				ext_q <= reg_wdata[3:0];
		end
	end
	a_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_base_clk_rd: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0C |-> reg_rdata == BASE_CLK_HZ)
		else $error("base clock read wrong");
	a_rate_rd: assert property ($past(reg_rd) && $past(reg_addr) == 8'h10 |-> reg_rdata == rate_q)
		else $error("rate divisor read wrong");
	a_sel_hold: assert property (!conv_start |-> $stable(conv_sel))
		else $error("selection moved without start");
	a_sw_single: assert property (start_wr && !reg_wdata[18] && rate_q == 32'h0 && !ext_q[0] |-> ##2 conv_start)
		else $error("software start missing");
	a_run_rise: assert property (start_wr && rate_q != 32'h0 |-> ##2 acq_running)
		else $error("run flag not raised");
	a_mode00_sel: assert property (conv_start && ctl_q[9:8] == 2'b00 && $past(ctl_q) == ctl_q
		|-> conv_sel == {ctl_q[2:0], 1'b0, ctl_q[6:4]})
		else $error("fixed mode selection wrong");
	a_ext_start: assert property ($rose(ext_start_in) && ext_q[2] && !ext_q[3] && !ctl_q[18] |-> ##[2:6] conv_start)
		else $error("external start lost");
endmodule
bind asc_seq_ctrl asc_chk #(.BASE_CLK_HZ(BASE_CLK_HZ)) asc_chk_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .ext_trig_in, .ext_start_in, .conv_start, .conv_sel, .acq_running);
`default_nettype wire

// ==== asc_cvm.sv ====
// Purpose: Converter model that logs every start
// Assumes: One sample per start pulse
// Notes:   Stamps use the cycle count before the edge
`timescale 1ns/1ps
`default_nettype none
module asc_cvm
	import asc_pkg::*;
(
	input wire logic      clk,
	input wire logic      resetn,
	input wire logic      conv_start,
	input wire asc_conv_s conv_sel
);
	int        cyc = 0;
	int        tq[$];
	asc_conv_s sq[$];
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (resetn && conv_start === 1'b1) begin
			tq.push_back(cyc);
			sq.push_back(conv_sel);
		end
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for the sequencer
// Assumes: Default base clock parameter
// Notes:   Expected conversions are queued from the channel order
`timescale 1ns/1ps
`default_nettype none
module tb
	import asc_pkg::*;
;
	logic        clk;
	logic        resetn;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        ext_trig_in;
	logic        ext_start_in;
	logic        conv_start;
	asc_conv_s   conv_sel;
	logic        acq_running;
	int          err_count = 0;
	int          checks = 0;
	int          seed = 38;
	int          tw;
	int          t0;
	int          to_cnt = 0;
	logic [31:0] k;
	logic [31:0] gains;
	logic [2:0]  ch;
	asc_conv_s   eq[$];
	asc_seq_ctrl asc_seq_ctrl_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ext_trig_in, .ext_start_in, .conv_start, .conv_sel, .acq_running);
	asc_cvm asc_cvm_inst (.clk, .resetn, .conv_start, .conv_sel);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic test_done();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Covers every scenario with margin; a hang counts as a mismatch
	always @(posedge clk) begin
		to_cnt++;
		if (to_cnt == 5000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		tw = asc_cvm_inst.cyc;
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, exp);
		@(posedge clk);
	endtask
	task automatic pin(input int n);
		repeat (n) begin
			ext_start_in <= 1'b1;
			repeat (4) @(posedge clk);
			ext_start_in <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task automatic clr();
		asc_cvm_inst.tq.delete();
		asc_cvm_inst.sq.delete();
	endtask
	task automatic gaps(input int from, input int d);
		for (int i = from; i < asc_cvm_inst.tq.size(); i++)
			chk("start_gap", asc_cvm_inst.tq[i] - asc_cvm_inst.tq[i-1], d);
	endtask
	task automatic cmp(input int lat);
		repeat (30) @(posedge clk);
		if (lat > 0)
			chk("start_delay", asc_cvm_inst.tq[0] - tw, lat);
		chk("conv_count", asc_cvm_inst.sq.size(), eq.size());
		foreach (eq[i])
			chk("conv_sel", asc_cvm_inst.sq[i], eq[i]);
		eq.delete();
		clr();
	endtask
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd, ext_trig_in, ext_start_in} = '0;
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h0C, ASC_BASE_CLK_HZ);
		rd(8'h18, 32'h0);
		rd(8'h7C, 32'h0);
		wr(8'h0C, 32'h0);
		rd(8'h0C, ASC_BASE_CLK_HZ);
		gains = $random(seed);
		wr(8'h18, gains);
		rd(8'h18, gains);
		k = $random(seed);
		wr(8'h10, k);
		rd(8'h10, k);
		wr(8'h10, 32'h0);
		for (int n = 0; n < 3; n++) begin
			k = $random(seed);
			wr(8'h38, 32'h1_0000 | (k & 32'h77) | (n == 1 ? 32'h4_0000 : 32'h0));
			eq.push_back({k[2:0], 1'b0, k[6:4]});
			cmp(2);
		end
		wr(8'h48, 32'h4);
		for (int m = 2; m < 4; m++) begin
			wr(8'h38, 32'h52 | (m << 8));
			for (int i = 0; i < 5; i++) begin
				ch = 3'(i % 3);
				eq.push_back({ch, m == 2 ? gains[4*ch +: 4] : 4'h5});
			end
			pin(5);
			cmp(0);
		end
		wr(8'h38, 32'h172);
		eq.push_back({3'h2, 4'h7});
		eq.push_back({3'h0, 4'h7});
		pin(2);
		cmp(0);
		wr(8'h48, 32'hC);
		wr(8'h38, 32'h35);
		repeat (10) @(posedge clk);
		clr();
		eq.push_back({3'h5, 4'h3});
		pin(1);
		cmp(0);
		wr(8'h48, 32'h0);
		wr(8'h10, 32'd20);
		wr(8'h38, 32'h1_0011);
		t0 = tw;
		repeat (70) @(posedge clk);
		chk("acq_running", acq_running, 1'b1);
		wr(8'h38, 32'h11);
		repeat (4) eq.push_back({3'h1, 4'h1});
		gaps(1, 20);
		tw = t0;
		cmp(2);
		chk("acq_running", acq_running, 1'b0);
		wr(8'h48, 32'h1);
		wr(8'h38, 32'h1_0011);
		repeat (40) @(posedge clk);
		chk("armed_quiet", asc_cvm_inst.tq.size(), 0);
		chk("acq_running", acq_running, 1'b1);
		ext_trig_in <= 1'b1;
		repeat (100) @(posedge clk);
		gaps(2, 20);
		chk("trig_starts", asc_cvm_inst.tq.size() > 3, 1'b1);
		wr(8'h38, 32'h11);
		ext_trig_in <= 1'b0;
		repeat (30) @(posedge clk);
		chk("acq_running", acq_running, 1'b0);
		clr();
		wr(8'h48, 32'h0);
		wr(8'h10, 32'h0);
		wr(8'h14, 32'd6);
		wr(8'h38, 32'h5_0203);
		for (int i = 0; i < 4; i++)
			eq.push_back({3'(i), gains[4*i +: 4]});
		repeat (25) @(posedge clk);
		gaps(1, 6);
		cmp(2);
		wr(8'h38, 32'h5_0200);
		eq.push_back({3'h0, gains[3:0]});
		cmp(2);
		wr(8'h10, 32'd20);
		wr(8'h38, 32'h1_0011);
		repeat (10) @(posedge clk);
		resetn <= 1'b0;
		repeat (6) @(posedge clk);
		chk("acq_running", acq_running, 1'b0);
		resetn <= 1'b1;
		rd(8'h10, 32'h0);
		clr();
		repeat (30) @(posedge clk);
		chk("after_reset", asc_cvm_inst.tq.size(), 0);
		test_done();
	end
endmodule
`default_nettype wire
